/* File: rtl/adc_config_input_trim_startup.sv */
// Converter configuration: serial control port, register file, clock divider,
// crosspoint routing, trim and current codes, start-up counter, jitter control.
// Assumes the serial pins are asynchronous to clk_sys_i and slow against it.
`timescale 1ns/1ns
module adc_config_input_trim_startup
    import adc_cfg_pkg::*;
#(
    parameter int WAKE_RANGE_4 = WAKE_COUNT_RANGE_4,
    parameter int WAKE_RANGE_0 = WAKE_COUNT_RANGE_0,
    parameter int WAKE_RANGE_1 = WAKE_COUNT_RANGE_1,
    parameter int WAKE_RANGE_2 = WAKE_COUNT_RANGE_2,
    parameter int WAKE_RANGE_3 = WAKE_COUNT_RANGE_3
)
(
    input wire logic clk_sys_i,
    input wire logic rst_b_i,
    input wire logic ce_i,
    input wire logic spi_sclk_i,
    input wire logic spi_sdata_i,
    input wire logic spi_sen_b_i,
    input wire logic wake_powerdown_i,
    input wire logic wake_sleep_i,
    output logic spi_sdout_o,
    output logic spi_sdout_oe_b_o,
    output logic sample_strobe_o,
    output logic [3:0][3:0] crosspoint_route_o,
    output logic [5:0] fullscale_trim_code_o,
    output logic [2:0] core_current_code_o,
    output logic [2:0] core_current_cut_o,
    output logic [1:0] common_mode_buffer_strength_o,
    output logic common_mode_buffer_enable_o,
    output logic clock_running_o,
    output logic [3:0] jitter_weight_o,
    output logic startup_busy_o,
    output logic startup_done_o
);

    initial
    begin
        if (WAKE_RANGE_4 * 8 >= (1 << WAKE_COUNT_WIDTH) || WAKE_RANGE_3 < 1)
        begin
            $error("adc_config_input_trim_startup: start-up count out of range");
        end
    end

    // ****************************************************************
    // Pin synchronisers
    // ****************************************************************
    logic [1:0] sclk_sync;
    logic [1:0] sdata_sync;
    logic [1:0] sen_b_sync;
    logic [1:0] wake_pd_sync;
    logic [1:0] wake_sl_sync;
    logic sclk_prev;
    logic sen_b_prev;
    logic wake_pd_prev;
    logic wake_sl_prev;

    always_ff @(posedge clk_sys_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            sclk_sync <= 2'h0;
            sdata_sync <= 2'h0;
            sen_b_sync <= 2'h3;
            wake_pd_sync <= 2'h0;
            wake_sl_sync <= 2'h0;
            sclk_prev <= 1'b0;
            sen_b_prev <= 1'b1;
            wake_pd_prev <= 1'b0;
            wake_sl_prev <= 1'b0;
        end
        else if (ce_i)
        begin
            sclk_sync <= {sclk_sync[0], spi_sclk_i};
            sdata_sync <= {sdata_sync[0], spi_sdata_i};
            sen_b_sync <= {sen_b_sync[0], spi_sen_b_i};
            wake_pd_sync <= {wake_pd_sync[0], wake_powerdown_i};
            wake_sl_sync <= {wake_sl_sync[0], wake_sleep_i};
            sclk_prev <= sclk_sync[1];
            sen_b_prev <= sen_b_sync[1];
            wake_pd_prev <= wake_pd_sync[1];
            wake_sl_prev <= wake_sl_sync[1];
        end
    end

    logic sclk_rise;
    logic sclk_fall;
    logic frame_active;
    logic wake_request;

    assign frame_active = !sen_b_sync[1] && !sen_b_prev;
    assign sclk_rise = frame_active && sclk_sync[1] && !sclk_prev;
    assign sclk_fall = frame_active && !sclk_sync[1] && sclk_prev;
    assign wake_request = (wake_pd_sync[1] && !wake_pd_prev)
        || (wake_sl_sync[1] && !wake_sl_prev);

    // ****************************************************************
    // Serial command shifter
    // ****************************************************************
    logic [CMD_BITS-2:0] shift_in;
    logic [4:0] bit_index;
    logic [CMD_BITS-1:0] command;
    logic command_done;
    logic [ADDR_BITS-1:0] cmd_addr;
    logic [15:0] cmd_data;

    assign command = {shift_in, sdata_sync[1]};
    assign command_done = sclk_rise && (bit_index == LAST_BIT_INDEX);
    assign cmd_addr = command[CMD_BITS-1 -: ADDR_BITS];
    assign cmd_data = command[15:0];

    always_ff @(posedge clk_sys_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            shift_in <= '0;
            bit_index <= 5'h00;
        end
        else if (ce_i)
        begin
            if (!frame_active)
            begin
                bit_index <= 5'h00;
            end
            else if (sclk_rise)
            begin
                shift_in <= command[CMD_BITS-2:0];
                if (bit_index != LAST_BIT_INDEX)
                begin
                    bit_index <= bit_index + 5'h01;
                end
                else
                begin
                    bit_index <= 5'h00;
                end
            end
        end
    end

    // ****************************************************************
    // Register file, one register written at command end, all at soft reset
    // ****************************************************************
    cfg_t cfg;
    logic write_hit;

    assign write_hit = command_done && !cmd_addr[POS_READ_FLAG];

    always_ff @(posedge clk_sys_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            cfg <= CFG_RESET;
        end
        else if (ce_i && write_hit)
        begin
            case (cmd_addr[6:0])
                ADDR_SOFT_RESET:
                begin
                    if (cmd_data[0])
                    begin
                        cfg <= CFG_RESET;
                    end
                end
                ADDR_CLOCK_JITTER_SETTING:
                begin
                    cfg.jitter <= cmd_data[7:0];
                end
                ADDR_OPERATING_MODE:
                begin
                    cfg.clk_divide <= cmd_data[POS_CLK_DIVIDE +: 2];
                    cfg.precision <= cmd_data[POS_PRECISION];
                    cfg.hs_mode <= cmd_data[POS_HS_MODE +: 3];
                end
                ADDR_CROSSPOINT_SELECT_LOW_PAIR:
                begin
                    cfg.src[0] <= cmd_data[POS_SRC_EVEN +: 5];
                    cfg.src[1] <= cmd_data[POS_SRC_ODD +: 5];
                end
                ADDR_CROSSPOINT_SELECT_HIGH_PAIR:
                begin
                    cfg.src[2] <= cmd_data[POS_SRC_EVEN +: 5];
                    cfg.src[3] <= cmd_data[POS_SRC_ODD +: 5];
                end
                ADDR_CORE_AND_BUFFER_CURRENT:
                begin
                    cfg.core_current <= cmd_data[POS_CORE_CURRENT +: 3];
                    cfg.buffer_strength <= cmd_data[POS_BUFFER_STRENGTH +: 2];
                end
                ADDR_FULL_SCALE_TRIM:
                begin
                    cfg.trim <= cmd_data[5:0];
                end
                ADDR_WAKEUP_COUNT_RANGE:
                begin
                    cfg.wake_range <= cmd_data[2:0];
                end
                default:
                begin
                    cfg <= cfg;
                end
            endcase
        end
    end

    // ****************************************************************
    // Readback: address bit 7 set turns the command into a read
    // ****************************************************************
    logic [15:0] read_word;
    logic [15:0] shift_out;
    logic read_phase;

    always_comb
    begin
        read_word = 16'h0000;
        case (command[6:0])
            ADDR_CLOCK_JITTER_SETTING: read_word = {8'h00, cfg.jitter};
            ADDR_OPERATING_MODE: read_word = {6'h00, cfg.clk_divide, 4'h0,
                cfg.precision, cfg.hs_mode};
            ADDR_CROSSPOINT_SELECT_LOW_PAIR: read_word = {3'h0, cfg.src[1], 3'h0, cfg.src[0]};
            ADDR_CROSSPOINT_SELECT_HIGH_PAIR: read_word = {3'h0, cfg.src[3], 3'h0, cfg.src[2]};
            ADDR_CORE_AND_BUFFER_CURRENT: read_word = {10'h000, cfg.buffer_strength, 1'b0,
                cfg.core_current};
            ADDR_FULL_SCALE_TRIM: read_word = {10'h000, cfg.trim};
            ADDR_WAKEUP_COUNT_RANGE: read_word = {13'h0000, cfg.wake_range};
            default: read_word = 16'h0000;
        endcase
    end

    always_ff @(posedge clk_sys_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            shift_out <= 16'h0000;
            read_phase <= 1'b0;
            spi_sdout_o <= 1'b0;
            spi_sdout_oe_b_o <= 1'b1;
        end
        else if (ce_i)
        begin
            if (!frame_active || command_done)
            begin
                read_phase <= 1'b0;
                spi_sdout_oe_b_o <= 1'b1;
            end
            else if (sclk_rise && bit_index == ADDR_DONE_INDEX && command[POS_READ_FLAG])
            begin
                shift_out <= read_word;
                read_phase <= 1'b1;
            end
            else if (sclk_fall && read_phase)
            begin
                spi_sdout_o <= shift_out[15];
                spi_sdout_oe_b_o <= 1'b0;
                shift_out <= {shift_out[14:0], 1'b0};
            end
        end
    end

    // ****************************************************************
    // Clock divider and jitter gate
    // ****************************************************************
    logic [2:0] div_count;
    logic [2:0] div_last;
    logic [3:0] next_weight;

    always_comb
    begin
        case (cfg.clk_divide)
            2'h0: div_last = 3'h0;
            2'h1: div_last = 3'h1;
            2'h2: div_last = 3'h3;
            default: div_last = 3'h7;
        endcase
    end

    always_comb
    begin
        next_weight = 4'h0;
        for (int i = 0; i < 8; i++)
        begin
            next_weight = next_weight + {3'h0, cfg.jitter[i]};
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            div_count <= 3'h0;
            sample_strobe_o <= 1'b0;
            clock_running_o <= 1'b0;
            jitter_weight_o <= 4'h0;
        end
        else if (ce_i)
        begin
            clock_running_o <= |cfg.jitter;
            jitter_weight_o <= next_weight;
            if (!(|cfg.jitter))
            begin
                div_count <= 3'h0;
                sample_strobe_o <= 1'b0;
            end
            else if (div_count >= div_last)
            begin
                div_count <= 3'h0;
                sample_strobe_o <= 1'b1;
            end
            else
            begin
                div_count <= div_count + 3'h1;
                sample_strobe_o <= 1'b0;
            end
        end
    end

    // ****************************************************************
    // Crosspoint routing per operating mode
    // ****************************************************************
    op_mode_t op_mode;
    logic [3:0][3:0] next_route;

    always_comb
    begin
        if (cfg.precision)
        begin
            op_mode = MODE_PRECISION;
        end
        else if (cfg.hs_mode == HS_MODE_SINGLE)
        begin
            op_mode = MODE_SINGLE;
        end
        else if (cfg.hs_mode == HS_MODE_DUAL)
        begin
            op_mode = MODE_DUAL;
        end
        else
        begin
            op_mode = MODE_QUAD;
        end
    end

    always_comb
    begin
        next_route = '0;
        for (int c = 0; c < 4; c++)
        begin
            case (op_mode)
                MODE_SINGLE: next_route[c] = cfg.src[0][4:1];
                MODE_DUAL: next_route[c] = (c < 2) ? cfg.src[0][4:1] : cfg.src[2][4:1];
                MODE_QUAD: next_route[c] = cfg.src[c][4:1];
                MODE_PRECISION: next_route[c] = cfg.src[c][4:1];
                default: next_route[c] = cfg.src[c][4:1];
            endcase
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            crosspoint_route_o <= {4'h8, 4'h4, 4'h2, 4'h1};
        end
        else if (ce_i)
        begin
            crosspoint_route_o <= next_route;
        end
    end

    // ****************************************************************
    // Trim, current and buffer codes
    // ****************************************************************
    logic [2:0] next_cut;

    always_comb
    begin
        case (cfg.core_current)
            3'h7: next_cut = 3'h1;
            3'h6: next_cut = 3'h2;
            3'h5: next_cut = 3'h3;
            3'h4: next_cut = 3'h4;
            default: next_cut = 3'h0;
        endcase
    end

    always_ff @(posedge clk_sys_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            fullscale_trim_code_o <= TRIM_MIDCODE;
            core_current_code_o <= CORE_CURRENT_NOMINAL;
            core_current_cut_o <= 3'h0;
            common_mode_buffer_strength_o <= BUFFER_STRENGTH_NOMINAL;
            common_mode_buffer_enable_o <= 1'b1;
        end
        else if (ce_i)
        begin
            fullscale_trim_code_o <= cfg.trim;
            core_current_code_o <= cfg.core_current;
            core_current_cut_o <= next_cut;
            common_mode_buffer_strength_o <= cfg.buffer_strength;
            common_mode_buffer_enable_o <= cfg.buffer_strength != BUFFER_STRENGTH_OFF;
        end
    end

    // ****************************************************************
    // Start-up length from range and mode
    // ****************************************************************
    logic [WAKE_COUNT_WIDTH-1:0] base_count;
    logic [WAKE_COUNT_WIDTH-1:0] wake_length;

    always_comb
    begin
        case (cfg.wake_range)
            3'h0: base_count = WAKE_COUNT_WIDTH'(WAKE_RANGE_0);
            3'h1: base_count = WAKE_COUNT_WIDTH'(WAKE_RANGE_1);
            3'h2: base_count = WAKE_COUNT_WIDTH'(WAKE_RANGE_2);
            3'h3: base_count = WAKE_COUNT_WIDTH'(WAKE_RANGE_3);
            default: base_count = WAKE_COUNT_WIDTH'(WAKE_RANGE_4);
        endcase
        case (op_mode)
            MODE_QUAD: wake_length = base_count << 1;
            MODE_DUAL: wake_length = base_count << 2;
            MODE_SINGLE: wake_length = base_count << 3;
            default: wake_length = base_count;
        endcase
    end

    logic counter_busy;
    logic counter_done;

    wake_counter #(
        .WIDTH(WAKE_COUNT_WIDTH)
    ) u_wake_counter (
        .clk_sys_i(clk_sys_i),
        .rst_b_i(rst_b_i),
        .ce_i(ce_i),
        .start_i(wake_request),
        .length_i(wake_length),
        .busy_o(counter_busy),
        .done_o(counter_done)
    );

    always_ff @(posedge clk_sys_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            startup_busy_o <= 1'b0;
            startup_done_o <= 1'b0;
        end
        else if (ce_i)
        begin
            startup_busy_o <= counter_busy;
            startup_done_o <= counter_done;
        end
    end

endmodule : adc_config_input_trim_startup

/* File: rtl/adc_cfg_pkg.sv */
// Shared constants and carrier types for the converter configuration block.
// Assumes a 16-bit register word and a 24-bit serial command (8 address, 16 data).
package adc_cfg_pkg;

    // ****************************************************************
    // Register offsets
    // ****************************************************************
    localparam logic [6:0] ADDR_SOFT_RESET = 7'h00;
    localparam logic [6:0] ADDR_CLOCK_JITTER_SETTING = 7'h30;
    localparam logic [6:0] ADDR_OPERATING_MODE = 7'h31;
    localparam logic [6:0] ADDR_CROSSPOINT_SELECT_LOW_PAIR = 7'h3A;
    localparam logic [6:0] ADDR_CROSSPOINT_SELECT_HIGH_PAIR = 7'h3B;
    localparam logic [6:0] ADDR_CORE_AND_BUFFER_CURRENT = 7'h50;
    localparam logic [6:0] ADDR_FULL_SCALE_TRIM = 7'h55;
    localparam logic [6:0] ADDR_WAKEUP_COUNT_RANGE = 7'h56;

    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int POS_SRC_EVEN = 0;
    localparam int POS_SRC_ODD = 8;
    localparam int POS_CORE_CURRENT = 0;
    localparam int POS_BUFFER_STRENGTH = 4;
    localparam int POS_CLK_DIVIDE = 8;
    localparam int POS_PRECISION = 3;
    localparam int POS_HS_MODE = 0;
    localparam int POS_READ_FLAG = 7;

    // ****************************************************************
    // Serial command framing
    // ****************************************************************
    localparam int CMD_BITS = 24;
    localparam int ADDR_BITS = 8;
    localparam logic [4:0] LAST_BIT_INDEX = 5'h17;
    localparam logic [4:0] ADDR_DONE_INDEX = 5'h07;

    // ****************************************************************
    // Reset values and encodings
    // ****************************************************************
    localparam logic [4:0] SRC_PAIR_1 = 5'h02;
    localparam logic [4:0] SRC_PAIR_2 = 5'h04;
    localparam logic [4:0] SRC_PAIR_3 = 5'h08;
    localparam logic [4:0] SRC_PAIR_4 = 5'h10;
    localparam logic [5:0] TRIM_MIDCODE = 6'h20;
    localparam logic [2:0] CORE_CURRENT_NOMINAL = 3'h0;
    localparam logic [1:0] BUFFER_STRENGTH_NOMINAL = 2'h1;
    localparam logic [1:0] BUFFER_STRENGTH_OFF = 2'h0;
    localparam logic [2:0] RANGE_DEFAULT = 3'h0;
    localparam logic [1:0] CLK_DIVIDE_BY_ONE = 2'h0;
    localparam logic [2:0] HS_MODE_SINGLE = 3'h1;
    localparam logic [2:0] HS_MODE_DUAL = 3'h2;
    localparam logic [2:0] HS_MODE_QUAD = 3'h4;
    localparam logic [7:0] JITTER_RESET = 8'h01;

    // ****************************************************************
    // Start-up counts for the precision clock ranges (cycles)
    // ****************************************************************
    localparam int WAKE_COUNT_RANGE_4 = 1536;
    localparam int WAKE_COUNT_RANGE_0 = 992;
    localparam int WAKE_COUNT_RANGE_1 = 640;
    localparam int WAKE_COUNT_RANGE_2 = 420;
    localparam int WAKE_COUNT_RANGE_3 = 260;
    localparam int WAKE_COUNT_WIDTH = 14;

    typedef enum logic [1:0]
    {
        MODE_QUAD = 2'b00,
        MODE_DUAL = 2'b01,
        MODE_SINGLE = 2'b10,
        MODE_PRECISION = 2'b11
    } op_mode_t;

    typedef struct packed
    {
        logic [7:0] jitter;
        logic precision;
        logic [2:0] hs_mode;
        logic [1:0] clk_divide;
        logic [3:0][4:0] src;
        logic [5:0] trim;
        logic [2:0] core_current;
        logic [1:0] buffer_strength;
        logic [2:0] wake_range;
    } cfg_t;

    localparam cfg_t CFG_RESET = '{
        jitter: JITTER_RESET,
        precision: 1'b0,
        hs_mode: HS_MODE_QUAD,
        clk_divide: CLK_DIVIDE_BY_ONE,
        src: {SRC_PAIR_4, SRC_PAIR_3, SRC_PAIR_2, SRC_PAIR_1},
        trim: TRIM_MIDCODE,
        core_current: CORE_CURRENT_NOMINAL,
        buffer_strength: BUFFER_STRENGTH_NOMINAL,
        wake_range: RANGE_DEFAULT
    };

endpackage : adc_cfg_pkg

/* File: rtl/wake_counter.sv */
// Start-up delay counter: counts a loaded length after a wake request.
// Assumes start and length come from logic on the same clock.
`timescale 1ns/1ns
module wake_counter
    import adc_cfg_pkg::*;
#(
    parameter int WIDTH = WAKE_COUNT_WIDTH
)
(
    input wire logic clk_sys_i,
    input wire logic rst_b_i,
    input wire logic ce_i,
    input wire logic start_i,
    input wire logic [WIDTH-1:0] length_i,
    output logic busy_o,
    output logic done_o
);

    initial
    begin
        if (WIDTH < 2 || WIDTH > 24)
        begin
            $error("wake_counter: WIDTH out of range");
        end
    end

    logic [WIDTH-1:0] remaining;

    // ****************************************************************
    // Count down; a new start restarts the count
    // ****************************************************************
    always_ff @(posedge clk_sys_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            remaining <= '0;
            busy_o <= 1'b0;
            done_o <= 1'b0;
        end
        else if (ce_i)
        begin
            done_o <= 1'b0;
            if (start_i)
            begin
                remaining <= length_i - WIDTH'(1);
                busy_o <= 1'b1;
            end
            else if (busy_o)
            begin
                if (remaining == '0)
                begin
                    busy_o <= 1'b0;
                    done_o <= 1'b1;
                end
                else
                begin
                    remaining <= remaining - WIDTH'(1);
                end
            end
        end
    end

endmodule : wake_counter

/* File: tb/adc_config_input_trim_startup_assertions.sv */
// Checker for the converter configuration block.
// Sees only the top module's ports; bound to it at the foot.
`timescale 1ns/1ns
module cfg_checker
(
    input wire logic clk_sys_i,
    input wire logic rst_b_i,
    input wire logic spi_sen_b_i,
    input wire logic wake_powerdown_i,
    input wire logic wake_sleep_i,
    input wire logic sample_strobe_o,
    input wire logic [3:0][3:0] crosspoint_route_o,
    input wire logic [5:0] fullscale_trim_code_o,
    input wire logic [2:0] core_current_code_o,
    input wire logic [2:0] core_current_cut_o,
    input wire logic [1:0] common_mode_buffer_strength_o,
    input wire logic common_mode_buffer_enable_o,
    input wire logic clock_running_o,
    input wire logic [3:0] jitter_weight_o,
    input wire logic startup_done_o,
    input wire logic startup_busy_o
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!rst_b_i);
    sequence idle_s;
        spi_sen_b_i [*8];
    endsequence
    sequence off_s;
        !clock_running_o [*2];
    endsequence
    AST_ROUTE: assert property (idle_s |=> $stable(crosspoint_route_o))
        else $error("route moved while idle");
    AST_TRIM: assert property (idle_s |=> $stable(fullscale_trim_code_o))
        else $error("trim moved while idle");
    AST_CUT: assert property (core_current_cut_o ==
        (core_current_code_o[2] ? 3'(4'h8 - core_current_code_o) : 3'h0))
        else $error("current cut wrong");
    AST_BUF: assert property (common_mode_buffer_enable_o
        == (common_mode_buffer_strength_o != 2'h0))
        else $error("buffer enable wrong");
    AST_CLK: assert property (clock_running_o == (jitter_weight_o != 4'h0))
        else $error("clock run flag wrong");
    AST_STOP: assert property (off_s |-> !sample_strobe_o)
        else $error("strobe with clock stopped");
    AST_PD: assert property ($rose(wake_powerdown_i) |-> ##[2:7] startup_busy_o)
        else $error("no count after power-down wake");
    AST_SL: assert property ($rose(wake_sleep_i) |-> ##[2:7] startup_busy_o)
        else $error("no count after sleep wake");
    AST_DONE: assert property ((startup_done_o |=> !startup_done_o)
        and ($fell(startup_busy_o) |-> startup_done_o))
        else $error("done pulse wrong");
endmodule : cfg_checker
bind adc_config_input_trim_startup cfg_checker chk (.*);

/* File: tb/spi_host_model.sv */
// Host on the serial control port: 24-bit frames, MSB first.
// Assumes a free-running system clock; changes pins at its falling edge.
`timescale 1ns/1ns
module spi_host_model
(
    input wire logic clk_sys_i,
    input wire logic sdout_i,
    output logic sclk_o,
    output logic sdata_o,
    output logic sen_b_o
);
    initial
    begin
        sclk_o = 1'b0;
        sdata_o = 1'b0;
        sen_b_o = 1'b1;
    end
    task xfer(input logic [23:0] cmd, output logic [15:0] rd);
        rd = 16'h0000;
        sen_b_o = 1'b0;
        for (int i = 23; i >= 0; i--)
        begin
            sclk_o = 1'b0;
            sdata_o = cmd[i];
            repeat (5) @(negedge clk_sys_i);
            if (i < 16) rd = {rd[14:0], sdout_i};
            sclk_o = 1'b1;
            repeat (5) @(negedge clk_sys_i);
        end
        sclk_o = 1'b0;
        repeat (5) @(negedge clk_sys_i);
        sen_b_o = 1'b1;
        // Released line must not keep its last value
        sdata_o = ~sdata_o;
        repeat (5) @(negedge clk_sys_i);
    endtask : xfer
endmodule : spi_host_model

/* File: tb/adc_config_input_trim_startup_test.sv */
// Testbench for the converter configuration block.
// Drives pins at the falling clock edge; the host model frames commands.
`timescale 1ns/1ns
module adc_config_input_trim_startup_test
    import adc_cfg_pkg::*;
;
    logic clk_sys_i = 0, rst_b_i = 0, ce_i = 1, wake_powerdown_i = 0, wake_sleep_i = 0;
    logic spi_sclk_i, spi_sdata_i, spi_sen_b_i, spi_sdout_o, spi_sdout_oe_b_o, sample_strobe_o;
    logic common_mode_buffer_enable_o, clock_running_o, startup_busy_o, startup_done_o;
    logic [3:0][3:0] crosspoint_route_o;
    logic [5:0] fullscale_trim_code_o;
    logic [2:0] core_current_code_o, core_current_cut_o;
    logic [1:0] common_mode_buffer_strength_o;
    logic [3:0] jitter_weight_o;
    logic [15:0] rd;
    int fails = 0, cmp_count = 0, cyc = 0, n0, n1, n3;
    always #50 clk_sys_i = ~clk_sys_i;
    adc_config_input_trim_startup #(.WAKE_RANGE_0(20), .WAKE_RANGE_1(16), .WAKE_RANGE_2(12),
        .WAKE_RANGE_3(10), .WAKE_RANGE_4(24)) DUT (.*);
    spi_host_model host (.clk_sys_i(clk_sys_i), .sdout_i(spi_sdout_o | spi_sdout_oe_b_o),
        .sclk_o(spi_sclk_i), .sdata_o(spi_sdata_i), .sen_b_o(spi_sen_b_i));
    task chk(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            fails++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task wr(input logic [7:0] a, input logic [15:0] d);
        host.xfer({a, d}, rd);
        repeat (3) @(negedge clk_sys_i);
    endtask : wr
    task wk(input logic s, output int n);
        n = 0;
        wake_sleep_i = s;
        wake_powerdown_i = ~s;
        repeat (2) @(negedge clk_sys_i);
        wake_sleep_i = 0;
        wake_powerdown_i = 0;
        repeat (8) @(negedge clk_sys_i);
        while (startup_busy_o === 1'b1 && n < 200)
        begin
            n++;
            @(negedge clk_sys_i);
        end
        repeat (4) @(negedge clk_sys_i);
    endtask : wk
    task conclude;
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : conclude
    always @(posedge clk_sys_i)
    begin
        cyc++;
        if (cyc == 30000)
        begin
            fails++;
            conclude;
        end
    end
    initial
    begin
        repeat (6) @(negedge clk_sys_i);
        rst_b_i = 1;
        @(negedge clk_sys_i);
        chk(crosspoint_route_o, 16'h8421);
        chk(fullscale_trim_code_o, 16'h0020);
        chk({spi_sdout_oe_b_o, common_mode_buffer_enable_o, common_mode_buffer_strength_o,
            core_current_code_o}, 16'h0068);
        for (int d = 0; d < 4; d++)
        begin
            if (d > 0) wr(8'h31, 16'h0004 | (d << 8));
            n0 = 0;
            repeat (16)
            begin
                @(negedge clk_sys_i);
                n0 += (sample_strobe_o === 1'b1);
            end
            chk(16'(n0), 16'h0010 >> d);
        end
        wr(8'hBA, 16'h0000);
        chk(rd, 16'h0402);
        $display("test reset and divider done");
        wr(8'h3A, 16'h1002);
        wr(8'h3B, 16'h0204);
        chk(crosspoint_route_o, 16'h1281);
        wr(8'h3A, 16'h0606);
        chk(crosspoint_route_o, 16'h1233);
        wr(8'hBA, 16'h0000);
        chk(rd, 16'h0606);
        wr(8'h31, 16'h0001);
        chk(crosspoint_route_o, 16'h3333);
        wr(8'h31, 16'h0002);
        chk(crosspoint_route_o, 16'h2233);
        wr(8'h31, 16'h0004);
        $display("test crosspoint done");
        wr(8'h55, 16'hFFFF);
        chk(fullscale_trim_code_o, 16'h003F);
        wr(8'hD5, 16'h0000);
        chk(rd, 16'h003F);
        // Core codes 001 to 011 are never written
        for (int c = 4; c < 8; c++)
        begin
            wr(8'h50, 16'(c + (c - 4) * 16));
            chk({core_current_cut_o, common_mode_buffer_enable_o, common_mode_buffer_strength_o},
                16'({3'(8 - c), c != 4, 2'(c - 4)}));
        end
        $display("test trim and current done");
        wr(8'h30, 16'h0000);
        repeat (3) @(negedge clk_sys_i);
        chk({clock_running_o, sample_strobe_o}, 16'h0000);
        for (int k = 0; k < 4; k++)
        begin
            wr(8'h30, 16'h0003 << (2 * k));
            chk(jitter_weight_o, 16'h0002);
        end
        $display("test jitter done");
        wr(8'h56, 16'h0000);
        wk(0, n0);
        wk(1, n1);
        chk(16'(n1), 16'(n0));
        // Undivided clock in quad mode, so each range count is doubled
        wr(8'h56, 16'h0003);
        wk(1, n3);
        chk(16'(n0 - n3), 16'h0014);
        $display("test start-up done");
        conclude;
    end
endmodule : adc_config_input_trim_startup_test
